// ---- rtl/uab_uart.v ----
`timescale 1ns/1ps
`default_nettype none
`include "uab_map.vh"
// Summary of operation
// RQ1 - The transmit-done flag rises after the eighth bit in shift mode or at the stop bit start otherwise, and stays until software clears it.
// RQ2 - The receive-done flag rises after the eighth bit in shift mode or mid stop bit otherwise, gated by the address filter, and only software clears it.
// RQ3 - An invalid stop bit sets the framing-error flag, which good frames never clear.
// RQ4 - The top control bit is the framing-error flag when the access select is 1 and the high mode bit when it is 0.
// RQ5 - Two mode bits pick shift register, 8-bit variable, 9-bit fixed or 9-bit variable operation.
// RQ6 - An address frame matches the given address when all bits with mask 1 equal the slave address.
// RQ7 - The broadcast address is slave address OR mask, with zero positions as don't-care.
// RQ8 - A master normally sends all ones as the broadcast address.
// RQ9 - The slave address register sits at A9H and the mask register at B9H.
// RQ10 - Reset clears both address registers so every address frame is accepted.
// RQ11 - Shift mode moves one bit every twelve oscillator periods.
// RQ12 - Fixed 9-bit mode runs at oscillator over 64, or over 32 with rate doubling.
// RQ13 - Variable modes take their rate from the first timer, the second timer, or one each way.
// RQ14 - With the first timer, the bit rate is its overflow rate over 32, doubled by the doubling bit.
// RQ15 - Software keeps the first timer's interrupt off while it paces the port.
// RQ16 - The first timer may be run in any running mode, usually 8-bit auto-reload.
// RQ17 - For very low rates software runs the first timer at 16 bits and reloads it by interrupt.
module uab_uart (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire timer1_overflow,
  input wire timer2_overflow,
  input wire rxd_in,
  output reg txd_out,
  output reg shift_clk_out,
  output wire irq
);
  localparam S_IDLE = 2'd0;
  localparam S_START = 2'd1;
  localparam S_DATA = 2'd2;
  localparam S_STOP = 2'd3;

  reg mode_select_high;
  reg mode_select_low;
  reg address_filter_enable;
  reg rx_enable;
  reg tx_ninth_bit;
  reg rx_ninth_bit;
  reg tx_done_flag;
  reg rx_done_flag;
  reg framing_error_flag;
  reg rate_doubling_bit;
  reg frame_error_access_select;
  reg [7:0] slave_address;
  reg [7:0] slave_address_mask;
  reg [1:0] rate_control;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [7:0] rx_data;
  reg [1:0] tx_state;
  reg [1:0] rx_state;
  reg [8:0] tx_shift;
  reg [3:0] tx_cnt;
  reg [8:0] rx_shift;
  reg [3:0] rx_cnt;
  reg rx_q;
  reg [6:0] tx_div;
  reg [6:0] rx_div;
  reg tx_tick;
  reg rx_tick;
  wire tx_full;
  wire rx_half;
  wire rx_full;
  wire [1:0] mode = {mode_select_high, mode_select_low};
  wire nine_bit = mode_select_high;
  wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the ack edge, the one edge the master commits on
  wire wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd = acc && !wb_we_i;
  wire wr_sc = wr && (wb_adr_i == `UAB_OFF_SERIAL_CONTROL);
  wire wr_tx = wr && (wb_adr_i == `UAB_OFF_TX_DATA);
  wire rd_st = rd && (wb_adr_i == `UAB_OFF_IRQ_STATUS);
  wire [7:0] wd = wb_dat_i[7:0];
  wire tx_start = wr_tx && (tx_state == S_IDLE);
  wire rx_start = (rx_state == S_IDLE) && rx_enable && !rx_done_flag
    && (mode == 2'b00 ? 1'b1 : (rx_q && !rxd_in));

  // tick source and divisor per mode
  always @*
  begin
    tx_tick = 1'b1;
    rx_tick = 1'b1;
    tx_div = 7'd`UAB_DIV_SHIFT;
    rx_div = 7'd`UAB_DIV_SHIFT;
    case (mode)
      // RQ11 fixed shift rate
      2'b00:
      begin
        tx_div = 7'd`UAB_DIV_SHIFT;
        rx_div = 7'd`UAB_DIV_SHIFT;
      end
      // RQ12 fixed nine-bit rate
      2'b10:
      begin
        tx_div = rate_doubling_bit ? 7'd`UAB_DIV_FIXED_FAST : 7'd`UAB_DIV_FIXED_SLOW;
        rx_div = tx_div;
      end
      // RQ13 RQ14 timer paced rates
      default:
      begin
        tx_tick = rate_control[`UAB_RC_TX_T2] ? timer2_overflow : timer1_overflow;
        rx_tick = rate_control[`UAB_RC_RX_T2] ? timer2_overflow : timer1_overflow;
        if (rate_control[`UAB_RC_TX_T2])
          tx_div = 7'd`UAB_DIV_T2;
        else
          tx_div = rate_doubling_bit ? 7'd`UAB_DIV_T1_FAST : 7'd`UAB_DIV_T1_SLOW;
        if (rate_control[`UAB_RC_RX_T2])
          rx_div = 7'd`UAB_DIV_T2;
        else
          rx_div = rate_doubling_bit ? 7'd`UAB_DIV_T1_FAST : 7'd`UAB_DIV_T1_SLOW;
      end
    endcase
  end

  uab_bitclk #(.W(7)) u_txclk (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(tx_start),
    .tick(tx_tick),
    .div(tx_div),
    .half(),
    .full(tx_full)
  );
  uab_bitclk #(.W(7)) u_rxclk (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(rx_start),
    .tick(rx_tick),
    .div(rx_div),
    .half(rx_half),
    .full(rx_full)
  );
  // transmit needs whole-bit strobes only, so its half strobe is left open

  // address filter
  wire [7:0] given_care = slave_address_mask;
  wire [7:0] bcast = slave_address | slave_address_mask;
  wire [7:0] rx_byte = nine_bit ? rx_shift[7:0] : rx_shift[8:1];
  // RQ6 given address compare
  wire given_hit = ((rx_byte ^ slave_address) & given_care) == 8'h00;
  // RQ7 broadcast compare
  wire bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
  // RQ10 zero registers accept all
  wire addr_hit = given_hit || bcast_hit;

  // transmitter
  reg tx_done_set;
  always @(posedge clk_sys)
  begin
    tx_done_set <= 1'b0;
    if (rst)
    begin
      tx_state <= S_IDLE;
      tx_shift <= 9'h1ff;
      tx_cnt <= 4'h0;
      txd_out <= 1'b1;
      shift_clk_out <= 1'b1;
    end
    else
    begin
      case (tx_state)
        S_IDLE:
          if (tx_start)
          begin
            tx_shift <= {tx_ninth_bit, wd};
            tx_cnt <= 4'h0;
            if (mode == 2'b00)
            begin
              txd_out <= wd[0];
              tx_state <= S_DATA;
            end
            else
            begin
              txd_out <= 1'b0;
              tx_state <= S_START;
            end
          end
        S_START:
          if (tx_full)
          begin
            txd_out <= tx_shift[0];
            tx_state <= S_DATA;
          end
        S_DATA:
          if (tx_full)
          begin
            tx_cnt <= tx_cnt + 4'h1;
            tx_shift <= {1'b1, tx_shift[8:1]};
            if (tx_cnt == (nine_bit ? 4'd8 : 4'd7))
            begin
              // RQ1 done at eighth bit or stop start
              tx_done_set <= 1'b1;
              txd_out <= 1'b1;
              tx_state <= (mode == 2'b00) ? S_IDLE : S_STOP;
            end
            else
              txd_out <= tx_shift[1];
          end
        default:
          if (tx_full)
            tx_state <= S_IDLE;
      endcase
      shift_clk_out <= !(mode == 2'b00 && tx_state == S_DATA) || tx_cnt[0] == 1'b0;
    end
  end

  // receiver; mode 0 samples rxd at each bit end
  reg rx_done_set;
  reg fe_set;
  reg rx_nb_set;
  reg rx_nb_val;
  always @(posedge clk_sys)
  begin
    rx_done_set <= 1'b0;
    fe_set <= 1'b0;
    rx_nb_set <= 1'b0;
    rx_nb_val <= 1'b0;
    if (rst)
    begin
      rx_state <= S_IDLE;
      rx_shift <= 9'h000;
      rx_cnt <= 4'h0;
      rx_q <= 1'b1;
      rx_data <= `UAB_RST_BYTE;
    end
    else
    begin
      rx_q <= rxd_in;
      case (rx_state)
        S_IDLE:
          if (rx_start)
          begin
            rx_cnt <= 4'h0;
            rx_state <= (mode == 2'b00) ? S_DATA : S_START;
          end
        S_START:
          if (rx_half)
            rx_state <= rxd_in ? S_IDLE : S_DATA;
        S_DATA:
          if ((mode == 2'b00) ? rx_full : rx_half)
          begin
            rx_shift <= {rxd_in, rx_shift[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (mode == 2'b00 && rx_cnt == 4'd7)
            begin
              // RQ2 shift mode done after eighth bit
              rx_data <= {rxd_in, rx_shift[8:2]};
              rx_done_set <= 1'b1;
              rx_state <= S_IDLE;
            end
            else if (rx_cnt == (nine_bit ? 4'd8 : 4'd7))
              rx_state <= S_STOP;
          end
        default:
          if (rx_half)
          begin
            rx_state <= S_IDLE;
            // RQ3 bad stop bit
            if (!rxd_in)
              fe_set <= 1'b1;
            // RQ2 mid stop bit, filter gated
            if (!address_filter_enable
                || (nine_bit ? (rx_shift[8] && addr_hit) : (rxd_in && addr_hit)))
            begin
              rx_data <= rx_byte;
              rx_nb_set <= 1'b1;
              rx_nb_val <= nine_bit ? rx_shift[8] : rxd_in;
              rx_done_set <= 1'b1;
            end
          end
      endcase
    end
  end

  // registers; hardware set wins over software clear
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_select_high <= 1'b0;
      mode_select_low <= 1'b0;
      address_filter_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      rate_doubling_bit <= 1'b0;
      frame_error_access_select <= 1'b0;
      // RQ10 address registers cleared
      slave_address <= `UAB_RST_BYTE;
      slave_address_mask <= `UAB_RST_BYTE;
      rate_control <= 2'b00;
      irq_status <= 3'b000;
      irq_mask <= 3'b000;
    end
    else
    begin
      if (wr_sc)
      begin
        // RQ4 top bit routed by access select
        if (frame_error_access_select)
          framing_error_flag <= wd[`UAB_SC_TOP];
        else
          mode_select_high <= wd[`UAB_SC_TOP];
        // RQ5 mode bits stored
        mode_select_low <= wd[`UAB_SC_MODE_LOW];
        address_filter_enable <= wd[`UAB_SC_FILTER];
        rx_enable <= wd[`UAB_SC_RX_EN];
        tx_ninth_bit <= wd[`UAB_SC_TX_NINTH];
        rx_ninth_bit <= wd[`UAB_SC_RX_NINTH];
        tx_done_flag <= wd[`UAB_SC_TX_DONE];
        rx_done_flag <= wd[`UAB_SC_RX_DONE];
      end
      // RQ9 address register decode
      if (wr && wb_adr_i == `UAB_OFF_SLAVE_ADDRESS)
        slave_address <= wd;
      if (wr && wb_adr_i == `UAB_OFF_SLAVE_ADDRESS_MASK)
        slave_address_mask <= wd;
      if (wr && wb_adr_i == `UAB_OFF_POWER_CONTROL)
      begin
        rate_doubling_bit <= wd[`UAB_PC_RATE_DOUBLE];
        frame_error_access_select <= wd[`UAB_PC_FE_ACCESS];
      end
      if (wr && wb_adr_i == `UAB_OFF_RATE_CONTROL)
        rate_control <= wd[1:0];
      if (wr && wb_adr_i == `UAB_OFF_IRQ_MASK)
        irq_mask <= wd[2:0];
      if (rx_nb_set)
        rx_ninth_bit <= rx_nb_val;
      // RQ1 sticky transmit flag
      if (tx_done_set)
        tx_done_flag <= 1'b1;
      // RQ2 sticky receive flag
      if (rx_done_set)
        rx_done_flag <= 1'b1;
      // RQ3 sticky framing flag
      if (fe_set)
        framing_error_flag <= 1'b1;
      irq_status <= (rd_st ? 3'b000 : irq_status) | {fe_set, rx_done_set, tx_done_set};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // wishbone: ack one cycle after strobe, dropped the cycle after
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (rd)
        case (wb_adr_i)
          `UAB_OFF_SERIAL_CONTROL:
            wb_dat_o[7:0] <= {frame_error_access_select ? framing_error_flag : mode_select_high,
              mode_select_low, address_filter_enable, rx_enable, tx_ninth_bit,
              rx_ninth_bit, tx_done_flag, rx_done_flag};
          `UAB_OFF_SLAVE_ADDRESS: wb_dat_o[7:0] <= slave_address;
          `UAB_OFF_SLAVE_ADDRESS_MASK: wb_dat_o[7:0] <= slave_address_mask;
          `UAB_OFF_POWER_CONTROL:
            wb_dat_o[7:0] <= {rate_doubling_bit, frame_error_access_select, 6'b00_0000};
          `UAB_OFF_RX_DATA: wb_dat_o[7:0] <= rx_data;
          `UAB_OFF_RATE_CONTROL: wb_dat_o[1:0] <= rate_control;
          `UAB_OFF_IRQ_STATUS: wb_dat_o[2:0] <= irq_status;
          `UAB_OFF_IRQ_MASK: wb_dat_o[2:0] <= irq_mask;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end
endmodule // uab_uart
`default_nettype wire

// ---- rtl/uab_map.vh ----
`ifndef UAB_MAP_VH
`define UAB_MAP_VH
// byte addresses on the wishbone side
`define UAB_OFF_SERIAL_CONTROL 8'h98
`define UAB_OFF_SLAVE_ADDRESS 8'ha9
`define UAB_OFF_SLAVE_ADDRESS_MASK 8'hb9
`define UAB_OFF_POWER_CONTROL 8'h87
`define UAB_OFF_TX_DATA 8'h99
`define UAB_OFF_RX_DATA 8'h9a
`define UAB_OFF_RATE_CONTROL 8'hc0
`define UAB_OFF_IRQ_STATUS 8'hc4
`define UAB_OFF_IRQ_MASK 8'hc8
// serial_control bits
`define UAB_SC_TOP 7
`define UAB_SC_MODE_LOW 6
`define UAB_SC_FILTER 5
`define UAB_SC_RX_EN 4
`define UAB_SC_TX_NINTH 3
`define UAB_SC_RX_NINTH 2
`define UAB_SC_TX_DONE 1
`define UAB_SC_RX_DONE 0
// power_control bits
`define UAB_PC_RATE_DOUBLE 7
`define UAB_PC_FE_ACCESS 6
// rate_control bits: 0 tx uses second timer tick, 1 rx uses second timer tick
`define UAB_RC_TX_T2 0
`define UAB_RC_RX_T2 1
// irq status bits
`define UAB_IRQ_TX 0
`define UAB_IRQ_RX 1
`define UAB_IRQ_FE 2
// reset values
`define UAB_RST_BYTE 8'h00
// divisors: oscillator periods for shift and fixed modes, timer overflow ticks for the T1 and T2 entries
`define UAB_DIV_SHIFT 12
`define UAB_DIV_FIXED_SLOW 64
`define UAB_DIV_FIXED_FAST 32
`define UAB_DIV_T1_SLOW 32
`define UAB_DIV_T1_FAST 16
`define UAB_DIV_T2 16
`endif

// ---- rtl/uab_bitclk.v ----
`timescale 1ns/1ps
`default_nettype none
// turns a source tick into one bit-time strobe every div ticks
module uab_bitclk #(
  parameter W = 7
) (
  input wire clk_sys,
  input wire rst,
  input wire restart,
  input wire tick,
  input wire [W-1:0] div,
  output reg half,
  output reg full
);
  reg [W-1:0] cnt;
  // strobes decoded directly, so the first bit after restart is not one cycle long
  always @*
  begin
    half = 1'b0;
    full = 1'b0;
    if (!rst && !restart && tick)
    begin
      half = (cnt == (div >> 1) - 1'b1);
      full = (cnt == div - 1'b1);
    end
  end
  always @(posedge clk_sys)
  begin
    if (rst || restart)
      cnt <= {W{1'b0}};
    else if (tick)
      cnt <= (cnt == div - 1'b1) ? {W{1'b0}} : cnt + 1'b1;
  end
endmodule // uab_bitclk
`default_nettype wire

// ---- dv/uab_uart_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module uab_uart_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic txd_out,
  input wire logic irq
);
  logic [1:0] mode;
  logic dbl, fea, sa_wr;
  logic [2:0] msk;
  logic [9:0] lowcnt;
  wire take_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd_ack = wb_ack_o && !wb_we_i;
  // low run length: in shift and fixed modes every low run on the line is whole bit times
  always_ff @(posedge clk_sys)
  begin
    lowcnt <= txd_out ? 10'h000 : lowcnt + 10'h001;
    if (rst)
    begin
      mode <= 2'b00;
      {dbl, fea, sa_wr} <= 3'b000;
      msk <= 3'b000;
    end
    else if (take_wr)
    begin
      if (wb_adr_i == 8'h98)
        mode <= {fea ? mode[1] : wb_dat_i[7], wb_dat_i[6]};
      if (wb_adr_i == 8'h87)
        {dbl, fea} <= wb_dat_i[7:6];
      if (wb_adr_i == 8'hc8)
        msk <= wb_dat_i[2:0];
      if (wb_adr_i == 8'ha9)
        sa_wr <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
  a_unmapped_zero: assert property (
    rd_ack && !(wb_adr_i inside {8'h98, 8'h99, 8'h9a, 8'ha9, 8'hb9, 8'h87, 8'hc0, 8'hc4, 8'hc8})
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_addr_reset_zero: assert property (
    rd_ack && wb_adr_i == 8'ha9 && !sa_wr |-> wb_dat_o[7:0] == 8'h00)
    else $error("slave address not zero after reset");
  a_top_bit_mode: assert property (
    rd_ack && wb_adr_i == 8'h98 && !fea |-> wb_dat_o[7] == mode[1])
    else $error("top control bit is not the mode bit");
  a_irq_needs_mask: assert property (
    irq |-> msk != 3'b000) else $error("irq with all sources masked");
  a_shift_bit_time: assert property (
    $rose(txd_out) && mode == 2'b00 |-> lowcnt % 12 == 0) else $error("shift bit time wrong");
  a_fixed_bit_time: assert property (
    $rose(txd_out) && mode == 2'b10 |-> lowcnt % (dbl ? 32 : 64) == 0)
    else $error("fixed rate bit time wrong");
  a_reset_idle: assert property (
    disable iff (1'b0) rst |=> !wb_ack_o && txd_out && !irq) else $error("outputs not idle in reset");
  c_ctrl_read: cover property (rd_ack && wb_adr_i == 8'h98);
  c_fixed_tx: cover property ($rose(txd_out) && mode == 2'b10);
  c_irq: cover property (irq);
endmodule // uab_uart_asserts
bind uab_uart uab_uart_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_out(txd_out), .irq(irq));
`default_nettype wire

// ---- dv/uab_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module uab_remote (
  input wire logic clk_sys,
  input wire logic txd_out,
  output logic rxd_in
);
  initial rxd_in = 1'b1;
  // start, data lsb first, stop
  task automatic send(input logic [8:0] f, input int nb, input int per, input logic stop);
    for (int i = -1; i <= nb; i++)
    begin
      @(posedge clk_sys);
      rxd_in <= (i < 0) ? 1'b0 : (i == nb) ? stop : f[i];
      repeat (per - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rxd_in <= 1'b1;
    repeat (per) @(posedge clk_sys);
  endtask
  // samples mid-bit; a missing frame comes back unknown
  task automatic get(input int nb, input int per, output logic [8:0] f);
    int k;
    k = 0;
    f = 9'h000;
    while (txd_out !== 1'b0 && k < 5000)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (per / 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++)
    begin
      repeat (per) @(posedge clk_sys);
      f[i] = txd_out;
    end
    if (k == 5000)
      f = 'x;
  endtask
endmodule // uab_remote
`default_nettype wire

// ---- dv/uab_uart_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module uab_uart_tb;
  typedef struct {logic [7:0] sc, pc, rc, d; int nb, per;} uab_tx_t;
  typedef struct {logic [8:0] f; logic hit;} uab_rx_t;
  uab_tx_t txr[6] = '{'{8'h88, 8'h00, 8'h00, 8'ha5, 9, 64}, '{8'h80, 8'h80, 8'h00, 8'h3c, 9, 32},
    '{8'h40, 8'h00, 8'h00, 8'h5a, 8, 64}, '{8'h40, 8'h80, 8'h00, 8'hc3, 8, 32},
    '{8'h40, 8'h00, 8'h01, 8'h69, 8, 64}, '{8'hc8, 8'h00, 8'h00, 8'h96, 9, 64}};
  // fourth row is the all-ones broadcast address
  uab_rx_t rxr[5] = '{'{9'h1f0, 1'b1}, '{9'h1f4, 1'b1}, '{9'h1f8, 1'b0}, '{9'h1ff, 1'b1},
    '{9'h0f0, 1'b0}};
  logic clk_sys = 0, rst = 1, we = 0, cyc = 0, stb = 0, t1 = 0, t2 = 0;
  logic ack, txd, sclk, irq, rxd;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q, rdat;
  logic [8:0] d;
  logic [1:0] tc = 2'b00;
  int n_fail = 0, compares = 0, i;
  always #25 clk_sys = ~clk_sys;
  // overflow ticks: first timer every 2 cycles, second every 4
  // bare overflow pulses, no timer interrupt or reload in play
  always @(posedge clk_sys)
  begin
    tc <= tc + 2'b01;
    t1 <= tc[0];
    t2 <= &tc;
  end
  uab_uart dut_u (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer1_overflow(t1), .timer2_overflow(t2), .rxd_in(rxd), .txd_out(txd),
    .shift_clk_out(sclk), .irq(irq));
  uab_remote rem_u (.clk_sys(clk_sys), .txd_out(txd), .rxd_in(rxd));
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v);
    int k;
    @(posedge clk_sys);
    adr <= a;
    we <= w;
    dat <= {24'h00_0000, v};
    {cyc, stb} <= 2'b11;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (k == 50)
    begin
      n_fail++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    wb(a, 1'b0, 8'h00);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      wb(8'h98, 1'b1, txr[i].sc);
      wb(8'h87, 1'b1, txr[i].pc);
      wb(8'hc0, 1'b1, txr[i].rc);
      wb(8'h99, 1'b1, txr[i].d);
      rem_u.get(txr[i].nb, txr[i].per, d);
      chk(d, {txr[i].nb == 9 && txr[i].sc[3], txr[i].d});
      if ($isunknown(d))
        give_verdict;
      repeat (2 * txr[i].per) @(posedge clk_sys);
      rd(8'h98);
      chk(9'(q[1]), 9'h001);
      @(negedge clk_sys);
      chk(9'(irq), 9'h000);
    end
    for (i = 0; i < 5; i++)
    begin
      if (i == 0)
      begin
        rd(8'ha9);
        chk(q[8:0], 9'h000);
        wb(8'ha9, 1'b1, 8'hf1);
        wb(8'hb9, 1'b1, 8'hfa);
        rd(8'hb9);
        chk(q[8:0], 9'h0fa);
      end
      wb(8'h98, 1'b1, 8'hb0);
      rem_u.send(rxr[i].f, 9, 64, 1'b1);
      rd(8'h98);
      chk(9'(q[0]), 9'(rxr[i].hit));
      rd(8'h9a);
      if (rxr[i].hit)
        chk(q[8:0], {1'b0, rxr[i].f[7:0]});
    end
    // interrupt: status already set while masked, then unmask and clear by read
    wb(8'hc8, 1'b1, 8'h01);
    @(negedge clk_sys);
    chk(9'(irq), 9'h001);
    rd(8'hc4);
    repeat (2) @(negedge clk_sys);
    chk({q[0], irq}, 9'h002);
    wb(8'h10, 1'b1, 8'hff);
    rd(8'h10);
    chk(q[8:0], 9'h000);
    wb(8'h87, 1'b1, 8'h40);
    wb(8'h98, 1'b1, 8'h10);
    rd(8'h98);
    chk(9'(q[7]), 9'h000);
    rem_u.send(9'h155, 9, 64, 1'b0);
    rd(8'h98);
    chk(9'(q[7]), 9'h001);
    wb(8'h98, 1'b1, 8'h90);
    rem_u.send(9'h0aa, 9, 64, 1'b1);
    rd(8'h98);
    chk(9'(q[7]), 9'h001);
    rd(8'hc4);
    chk(9'(q[2]), 9'h001);
    wb(8'h87, 1'b1, 8'h00);
    rd(8'h98);
    chk(9'(q[7]), 9'h001);
    wb(8'h98, 1'b1, 8'h00);
    wb(8'h99, 1'b1, 8'h96);
    repeat (60) @(posedge clk_sys);
    rd(8'h98);
    chk(9'(q[1]), 9'h000);
    repeat (50) @(posedge clk_sys);
    rd(8'h98);
    chk(9'(q[1]), 9'h001);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'hb9);
    chk(q[8:0], 9'h000);
    chk({txd, sclk}, 9'h003);
    give_verdict;
  end
endmodule // uab_uart_tb
`default_nettype wire
